//--- codec_link_pkg.sv
// Package of shared constants and carriers for the codec link pin block
`default_nettype none
package codec_link_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned FRAME_RATE_HZ = 48_000;
    localparam int unsigned BIT_CLK_KHZ = 12_288;
    // Bit clocks per frame: 12.288 MHz / 48 kHz
    localparam int unsigned FRAME_BITS = (BIT_CLK_KHZ * 1000) / FRAME_RATE_HZ;
    localparam int unsigned SYNC_HIGH_BITS = 16;
    localparam int unsigned SERIAL_IN_LINES = 2;
    localparam int unsigned FRAME_CNT_W = $clog2(FRAME_BITS);

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RESET_OUT_LEVEL = 1'b0;
    localparam logic STRAP_RESET_VALUE = 1'b0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic sync;
        logic data;
    } link_out_t;

    typedef struct packed {
        logic valid;
        logic [SERIAL_IN_LINES-1:0] bits;
    } link_in_t;
endpackage
`default_nettype wire

//--- bit_clock_framer.sv
// Frame sync and serial shifting logic on the codec bit clock
`default_nettype none
module bit_clock_framer
    import codec_link_pkg::*;
#(
    parameter int unsigned FRAME_LEN = FRAME_BITS,
    parameter int unsigned SYNC_LEN = SYNC_HIGH_BITS
) (
    // Link clock and reset
    input wire logic codecBitClock,
    input wire logic linkResetn,
    // Link pins
    output var link_out_t linkOut,
    input wire logic [SERIAL_IN_LINES-1:0] linkSerialIn,
    // Frame data
    input wire logic txBit,
    output logic txTake,
    output var link_in_t rxSample
);
    // Refuse frame shapes the counter cannot serve
    if (SYNC_LEN == 0 || SYNC_LEN >= FRAME_LEN || FRAME_LEN > (1 << FRAME_CNT_W)) begin
        $error("bit_clock_framer: bad frame parameters");
    end

    logic [FRAME_CNT_W-1:0] bitCnt_q, bitCnt_d;
    link_out_t out_q, out_d;
    link_in_t in_q, in_d;

    // ****************************************
    // Frame counter and output drive
    // ****************************************
    always_comb begin
        bitCnt_d = (bitCnt_q == FRAME_CNT_W'(FRAME_LEN - 1)) ? '0 : bitCnt_q + 1'b1;
        out_d.sync = (bitCnt_d < FRAME_CNT_W'(SYNC_LEN)); // [R2]
        out_d.data = txBit; // [R4]
        in_d.valid = 1'b1;
        in_d.bits = linkSerialIn; // [R5]
    end

    // Outputs launched on rising edge, inputs caught on falling edge
    always_ff @(posedge codecBitClock or negedge linkResetn) begin
        if (!linkResetn) begin
            bitCnt_q <= FRAME_CNT_W'(FRAME_LEN - 1);
            out_q <= '0; // [R8]
        end else begin
            bitCnt_q <= bitCnt_d;
            out_q <= out_d;
        end
    end

    always_ff @(negedge codecBitClock or negedge linkResetn) begin
        if (!linkResetn) begin
            in_q <= '0;
        end else begin
            in_q <= in_d;
        end
    end

    assign linkOut = out_q;
    assign txTake = linkResetn;
    assign rxSample = in_q;
endmodule
`default_nettype wire

//--- audio_codec_link_pins.sv
// Host pin logic of the serial audio codec link
//
// Contract
// R1: The host drives an active-low reset output that is master reset of all codecs.
// R2: The host drives frame sync at a fixed 48 kHz, marking the start of each frame.
// R3: The codec makes the 12.288 MHz bit clock and the host times link data with it.
// R4: The host sends outgoing data as one serial TDM output stream.
// R5: The host accepts serial TDM input data on two lines, indexed 1 down to 0.
// R6: The host samples its serial data output pin at power-good rising and keeps it as a strap.
// R7: Link shutoff at 1 enables pull-downs on bit clock and both data inputs, at 0 disables them.
// R8: While codec reset is asserted, frame sync and serial data out are held low.
`default_nettype none
module audio_codec_link_pins
    import codec_link_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic codecResetReq,
    input wire logic linkShutoff,
    input wire logic powerGood,
    output logic strapValue,
    // Outgoing data, system domain
    input wire logic txBit,
    // Incoming data, system domain
    output logic [SERIAL_IN_LINES-1:0] rxBits,
    output logic rxValid,
    // Link pins
    input wire logic codecBitClock,
    output logic codecReset_n,
    output logic frameSync,
    output logic linkSerialOut_o,
    output logic linkSerialOut_oe,
    input wire logic linkSerialOut_i,
    input wire logic [SERIAL_IN_LINES-1:0] linkSerialIn,
    output logic bitClockPullDown,
    output logic [SERIAL_IN_LINES-1:0] serialInPullDown
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    // Frame must hold a whole number of bit clocks
    if (FRAME_BITS * FRAME_RATE_HZ != BIT_CLK_KHZ * 1000) begin
        $error("audio_codec_link_pins: bit clock is not a whole multiple of the frame rate");
    end
    // Sync pulse must fit inside one frame
    if (SYNC_HIGH_BITS == 0 || SYNC_HIGH_BITS >= FRAME_BITS) begin
        $error("audio_codec_link_pins: sync pulse does not fit the frame");
    end
    if (SERIAL_IN_LINES < 1) begin
        $error("audio_codec_link_pins: no serial input lines");
    end

    // ****************************************
    // Codec reset output
    // ****************************************
    logic codecRst_q, codecRst_d;
    always_comb begin
        codecRst_d = ~codecResetReq; // [R1]
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            codecRst_q <= RESET_OUT_LEVEL;
        end else begin
            codecRst_q <= codecRst_d;
        end
    end
    assign codecReset_n = codecRst_q; // [R1]

    // ****************************************
    // Link-side reset
    // ****************************************
    // Asserted at once, released on the bit clock
    logic [1:0] linkRstSync_q, linkRstSync_d;
    always_comb begin
        linkRstSync_d = {linkRstSync_q[0], 1'b1};
    end
    always_ff @(posedge codecBitClock or negedge codecRst_q) begin
        if (!codecRst_q) begin
            linkRstSync_q <= 2'h0;
        end else begin
            linkRstSync_q <= linkRstSync_d;
        end
    end

    // ****************************************
    // Transmit bit crossing to link domain
    // ****************************************
    logic [1:0] txSync_q, txSync_d;
    always_comb begin
        txSync_d = {txSync_q[0], txBit};
    end
    always_ff @(posedge codecBitClock or negedge codecRst_q) begin
        if (!codecRst_q) begin
            txSync_q <= 2'h0;
        end else begin
            txSync_q <= txSync_d;
        end
    end

    link_out_t linkOut;
    link_in_t rxSample;

    bit_clock_framer #(
        .FRAME_LEN(FRAME_BITS),
        .SYNC_LEN(SYNC_HIGH_BITS)
    ) framer (
        .codecBitClock(codecBitClock), // [R3]
        .linkResetn(linkRstSync_q[1]),
        .linkOut(linkOut),
        .linkSerialIn(linkSerialIn),
        .txBit(txSync_q[1]),
        .txTake(),
        .rxSample(rxSample)
    );

    // Outputs forced low during codec reset
    assign frameSync = linkOut.sync & codecRst_q; // [R8]
    assign linkSerialOut_o = linkOut.data & codecRst_q; // [R8]

    // ****************************************
    // Power-good synchroniser and pin drive
    // ****************************************
    logic [1:0] powerGoodSync_q, powerGoodSync_d;
    logic powerGoodLast_q, powerGoodLast_d;
    always_comb begin
        powerGoodSync_d = {powerGoodSync_q[0], powerGood};
        powerGoodLast_d = powerGoodSync_q[1];
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            powerGoodSync_q <= 2'h0;
            powerGoodLast_q <= 1'b0;
        end else begin
            powerGoodSync_q <= powerGoodSync_d;
            powerGoodLast_q <= powerGoodLast_d;
        end
    end
    // Pin floats until power-good is seen, so the board strap shows
    assign linkSerialOut_oe = powerGoodSync_q[1]; // [R6]

    // ****************************************
    // Receive data crossing to system domain
    // ****************************************
    // Each line carries its own stream and crosses on its own
    for (genvar i = 0; i < SERIAL_IN_LINES; i++) begin : rxLine
        logic rxMeta_q, rxSync_q, rxBit_q;
        logic rxMeta_d, rxSync_d, rxBit_d;
        always_comb begin
            rxMeta_d = rxSample.bits[i]; // [R5]
            rxSync_d = rxMeta_q;
            rxBit_d = rxSync_q;
        end
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                rxMeta_q <= 1'b0;
                rxSync_q <= 1'b0;
                rxBit_q <= 1'b0;
            end else begin
                rxMeta_q <= rxMeta_d;
                rxSync_q <= rxSync_d;
                rxBit_q <= rxBit_d;
            end
        end
        assign rxBits[i] = rxBit_q; // [R5]
    end

    logic rxValidMeta_q, rxValidSync_q, rxValid_q;
    logic rxValidMeta_d, rxValidSync_d, rxValid_d;
    always_comb begin
        rxValidMeta_d = rxSample.valid;
        rxValidSync_d = rxValidMeta_q;
        rxValid_d = rxValidSync_q;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxValidMeta_q <= 1'b0;
            rxValidSync_q <= 1'b0;
            rxValid_q <= 1'b0;
        end else begin
            rxValidMeta_q <= rxValidMeta_d;
            rxValidSync_q <= rxValidSync_d;
            rxValid_q <= rxValid_d;
        end
    end
    assign rxValid = rxValid_q;

    // ****************************************
    // Power-good strap capture
    // ****************************************
    logic [1:0] pinSync_q, pinSync_d;
    logic strap_q, strap_d;
    always_comb begin
        pinSync_d = {pinSync_q[0], linkSerialOut_i};
        strap_d = strap_q;
        // Pin level seen while it still floated
        if (powerGoodSync_q[1] && !powerGoodLast_q) begin
            strap_d = pinSync_q[1]; // [R6]
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinSync_q <= 2'h0;
            strap_q <= STRAP_RESET_VALUE;
        end else begin
            pinSync_q <= pinSync_d;
            strap_q <= strap_d;
        end
    end
    assign strapValue = strap_q;

    // ****************************************
    // Input pull-down control
    // ****************************************
    logic pullDown_q, pullDown_d;
    always_comb begin
        pullDown_d = linkShutoff; // [R7]
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pullDown_q <= 1'b0;
        end else begin
            pullDown_q <= pullDown_d;
        end
    end
    assign bitClockPullDown = pullDown_q; // [R7]
    assign serialInPullDown = {SERIAL_IN_LINES{pullDown_q}}; // [R7]
endmodule
`default_nettype wire

//--- codec_model.sv
// Behavioural codec on the far side of the link
`default_nettype none
module codec_model #(
    parameter logic STRAP_LEVEL = 1'b1
) (
    // Pins from the host
    input wire logic codecReset_n,
    input wire logic linkSerialOut_o,
    input wire logic linkSerialOut_oe,
    input wire logic [1:0] serialInPullDown,
    // Bench data
    input wire logic [1:0] dataIn,
    // Pins to the host
    output logic codecBitClock,
    output logic [1:0] linkSerialIn,
    output logic linkSerialOut_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial codecBitClock = 1'b0;
    // Clock stands still while held in reset
    always #40 codecBitClock <= codecReset_n ? ~codecBitClock : 1'b0;
    // Released lines fall to pull-down or show inverse
    assign linkSerialIn = codecReset_n ? dataIn : (serialInPullDown & ~dataIn) ^ ~dataIn;
    // Board strap resistor while host floats the pin
    assign linkSerialOut_i = linkSerialOut_oe ? linkSerialOut_o : STRAP_LEVEL;
endmodule
`default_nettype wire

//--- audio_codec_link_chk.sv
// Assertion checker for the codec link pin block
`default_nettype none
module audio_codec_link_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic codecResetReq,
    input wire logic linkShutoff,
    input wire logic powerGood,
    input wire logic strapValue,
    input wire logic codecBitClock,
    input wire logic codecReset_n,
    input wire logic frameSync,
    input wire logic linkSerialOut_o,
    input wire logic linkSerialOut_oe,
    input wire logic linkSerialOut_i,
    input wire logic bitClockPullDown,
    input wire logic [1:0] serialInPullDown
);
    timeunit 1ns;
    timeprecision 100ps;
    sequence s_sync_high;
        frameSync[*8] ##1 frameSync[*8];
    endsequence
    a_reset_follows: assert property (@(posedge clk) disable iff (!resetn)
        1 |=> codecReset_n == !$past(codecResetReq)) else $error("codec reset wrong");
    a_sync_width: assert property (@(posedge codecBitClock) disable iff (!codecReset_n)
        $rose(frameSync) |-> s_sync_high ##1 !frameSync) else $error("sync width wrong");
    a_sync_period: assert property (@(posedge codecBitClock) disable iff (!codecReset_n)
        $rose(frameSync) |-> ##256 $rose(frameSync)) else $error("frame period wrong");
    a_strap_caught: assert property (@(posedge clk) disable iff (!resetn)
        $rose(powerGood) |-> ##5 strapValue == $past(linkSerialOut_i, 5)) else $error("strap wrong");
    a_strap_float: assert property (@(posedge clk) disable iff (!resetn)
        $rose(powerGood) |-> !linkSerialOut_oe[*2]) else $error("strap pin driven");
    a_pull_follow: assert property (@(posedge clk) disable iff (!resetn)
        1 |=> bitClockPullDown == $past(linkShutoff) && serialInPullDown == {2{$past(linkShutoff)}})
        else $error("pull-down wrong");
    a_quiet_reset: assert property (@(posedge clk) disable iff (!resetn)
        !codecReset_n |-> !frameSync && !linkSerialOut_o) else $error("link active in reset");
endmodule
bind audio_codec_link_pins audio_codec_link_chk chk (.clk(clk), .resetn(resetn),
    .codecResetReq(codecResetReq), .linkShutoff(linkShutoff), .powerGood(powerGood),
    .strapValue(strapValue), .codecBitClock(codecBitClock), .codecReset_n(codecReset_n),
    .frameSync(frameSync), .linkSerialOut_o(linkSerialOut_o), .linkSerialOut_oe(linkSerialOut_oe),
    .linkSerialOut_i(linkSerialOut_i), .bitClockPullDown(bitClockPullDown),
    .serialInPullDown(serialInPullDown));
`default_nettype wire

//--- tb_top.sv
// Testbench for the codec link pin block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import codec_link_pkg::*;
    logic clk, resetn, codecResetReq, linkShutoff, powerGood, txBit, strapValue, rxValid;
    logic codecBitClock, codecReset_n, frameSync, sOut, sOe, sIn, bitClockPullDown;
    logic [1:0] rxBits, linkSerialIn, serialInPullDown, dataIn;
    int fails = 0;
    int checksDone = 0;
    audio_codec_link_pins dut (.clk(clk), .resetn(resetn), .codecResetReq(codecResetReq),
        .linkShutoff(linkShutoff), .powerGood(powerGood), .strapValue(strapValue), .txBit(txBit),
        .rxBits(rxBits), .rxValid(rxValid), .codecBitClock(codecBitClock), .codecReset_n(codecReset_n),
        .frameSync(frameSync), .linkSerialOut_o(sOut), .linkSerialOut_oe(sOe), .linkSerialOut_i(sIn),
        .linkSerialIn(linkSerialIn), .bitClockPullDown(bitClockPullDown),
        .serialInPullDown(serialInPullDown));
    codec_model #(.STRAP_LEVEL(1'b1)) partner (.codecReset_n(codecReset_n), .linkSerialOut_o(sOut),
        .linkSerialOut_oe(sOe), .serialInPullDown(serialInPullDown), .dataIn(dataIn),
        .codecBitClock(codecBitClock), .linkSerialIn(linkSerialIn), .linkSerialOut_i(sIn));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d fails %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bit clocks until frame sync shows the level
    task automatic waitLvl(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge codecBitClock);
            #1;
            n++;
        end while (frameSync !== lvl && n < 600);
        if (n >= 600) begin
            fails++;
            summarize();
        end
    endtask
    task automatic t_reset;
        chk(codecReset_n, 16'h0000);
        chk({frameSync, sOut}, 16'h0000);
        chk(sOe, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_shutoff;
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk) linkShutoff <= v[0];
            settle(2);
            chk({bitClockPullDown, serialInPullDown}, {13'h0000, {3{v[0]}}});
        end
        $display("shutoff test done");
    endtask
    task automatic t_strap;
        @(posedge clk) powerGood <= 1'b1;
        settle(6);
        chk(strapValue, 16'h0001);
        chk(sOe, 16'h0001);
        $display("strap test done");
    endtask
    task automatic t_link;
        int h, l;
        @(posedge clk) codecResetReq <= 1'b0;
        txBit <= 1'b1;
        dataIn <= 2'h2;
        settle(2);
        chk(codecReset_n, 16'h0001);
        if (codecReset_n !== 1'b1) summarize();
        waitLvl(1'b1, h);
        waitLvl(1'b0, h);
        waitLvl(1'b1, l);
        chk(h, 16'h0010);
        chk(h + l, 16'h0100);
        chk({sOut, rxValid, rxBits}, 16'h000e);
        @(posedge clk) txBit <= 1'b0;
        dataIn <= 2'h1;
        repeat (12) @(posedge codecBitClock);
        #1;
        chk({sOut, rxValid, rxBits}, 16'h0005);
        $display("link test done");
    endtask
    task automatic t_relink;
        @(posedge clk) codecResetReq <= 1'b1;
        txBit <= 1'b1;
        settle(3);
        chk({codecReset_n, frameSync, sOut}, 16'h0000);
        $display("relink test done");
    endtask
    initial begin
        resetn = 1'b0;
        codecResetReq = 1'b1;
        linkShutoff = 1'b0;
        powerGood = 1'b0;
        txBit = 1'b0;
        dataIn = 2'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        settle(1);
        t_reset();
        t_shutoff();
        t_strap();
        t_link();
        t_relink();
        summarize();
    end
endmodule
`default_nettype wire
